// ===== link_capture_model.sv
// Behavioural far-end device that captures the marked link bits
`timescale 1ns/100ps
module link_capture_model (
  input  wire logic        line_clk_i,
  input  wire logic        t1_i,
  input  wire logic        form_i,
  input  wire logic        stream_i,
  input  wire logic        strobe_i,
  output logic      [15:0] count_o,
  output logic      [31:0] bits_o
);
  initial begin
    count_o = 16'h0000;
    bits_o  = 32'h0000_0000;
  end
  task automatic take(input logic b);
    count_o = count_o + 16'h0001;
    bits_o  = {bits_o[30:0], b};
  endtask
  always @(posedge strobe_i) if (form_i) take(stream_i);
  // Enable form: sample mid bit, away from the launch edge
  always @(negedge line_clk_i) if (!form_i && t1_i && strobe_i) take(stream_i);
  always @(posedge line_clk_i) if (!form_i && !t1_i && strobe_i) take(stream_i);
endmodule // link_capture_model

// ===== link_fifo.sv
// Parameterised valid/ready FIFO for the received line bits
`timescale 1ns/100ps
module link_fifo
  import rx_link_tap_pkg::*;
#(
  parameter int unsigned W = 2,
  parameter int unsigned D = 8
) (
  input  wire logic         clk_sys_i,
  input  wire logic         rst_n_i,
  input  wire logic         in_valid_i,
  output logic              in_ready_o,
  input  wire logic [W-1:0] in_data_i,
  output logic              out_valid_o,
  input  wire logic         out_ready_i,
  output logic      [W-1:0] out_data_o
);

  localparam int unsigned AW = $clog2(D);

  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW-1:0]       wr_ptr;
    logic [AW-1:0]       rd_ptr;
    logic [AW:0]         count;
  } fifo_state_type;

  fifo_state_type state_r;
  fifo_state_type state_nxt;
  logic           push;
  logic           pop;

  assign in_ready_o  = (state_r.count < (AW+1)'(D));
  assign out_valid_o = (state_r.count != '0);
  assign out_data_o  = state_r.mem[state_r.rd_ptr];
  assign push        = in_valid_i & in_ready_o;
  assign pop         = out_ready_i & out_valid_o;

  always_comb begin
    state_nxt = state_r;
    if (push) begin
      state_nxt.mem[state_r.wr_ptr] = in_data_i;
      state_nxt.wr_ptr = (state_r.wr_ptr == AW'(D - 1)) ? '0 : state_r.wr_ptr + 1'b1;
    end
    if (pop) begin
      state_nxt.rd_ptr = (state_r.rd_ptr == AW'(D - 1)) ? '0 : state_r.rd_ptr + 1'b1;
    end
    if (push && !pop) begin
      state_nxt.count = state_r.count + 1'b1;
    end else if (pop && !push) begin
      state_nxt.count = state_r.count - 1'b1;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_r <= '0;
    end else begin
      state_r <= state_nxt;
    end
  end

endmodule // link_fifo

// ===== link_sync.sv
// Two-stage synchroniser with edge detection for line-side inputs
`timescale 1ns/100ps
module link_sync
  import rx_link_tap_pkg::*;
#(
  parameter int unsigned W = 4
) (
  input  wire logic         clk_sys_i,
  input  wire logic         rst_n_i,
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] level_o,
  output logic      [W-1:0] rise_o,
  output logic      [W-1:0] fall_o
);

  typedef struct packed {
    logic [W-1:0] meta_r;
    logic [W-1:0] sync_r;
    logic [W-1:0] last_r;
  } sync_state_type;

  sync_state_type state_r;
  sync_state_type state_nxt;

  always_comb begin
    state_nxt        = state_r;
    state_nxt.meta_r = async_i;
    state_nxt.sync_r = state_r.meta_r;
    state_nxt.last_r = state_r.sync_r;
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_r <= '0;
    end else begin
      state_r <= state_nxt;
    end
  end

  // First stage feeds only the second stage
  assign level_o = state_r.sync_r;
  assign rise_o  = state_r.sync_r & ~state_r.last_r;
  assign fall_o  = ~state_r.sync_r & state_r.last_r;

endmodule // link_sync

// ===== receive_link_tap.sv
// Eight-lane receive data link tap: line stream and link strobe outputs
//
// Operation
// - Each lane outputs the whole decoded line stream, framing bits included, on its line clock.
// - The stream never passes a slip buffer and follows only the extracted line clock.
// - In T1 the stream runs at the line rate and each bit is launched on the line clock rise.
// - In E1 the stream runs at the line rate and each bit is launched on the line clock fall.
// - The link strobe marks the embedded data link bits inside the stream.
// - In T1 without inverse mux the gapped strobe is a 4 kHz clock on whose rise the far end samples.
// - In T1 the gapped strobe rise sits mid S-bit, on a falling edge of the line clock.
// - A form select input picks a gapped clock or an enable for the strobe.
// - In T1 inverse mux the strobe copies the line clock and the stream stays in step with it.
// - Inverse mux is active only while its mode bit is 1.
// - In E1 the strobe marks chosen national bits 4 to 8 of timeslot 0 of non-alignment frames.
// - In E1 the gapped strobe averages 4 kHz per chosen national bit, 4 to 20 kHz.
// - In E1 inverse mux the strobe is a clock at twice the line clock rate.
// - There are eight independent lanes, each driven only by its own framer.
// - Carrier select 0 means E1, otherwise T1.
`timescale 1ns/100ps
module receive_link_tap
  import rx_link_tap_pkg::*;
(
  input  wire logic                       clk_sys_i,
  input  wire logic                       rst_n_i,
  input  wire logic [LANES-1:0]           extracted_line_clock_in_i,
  input  wire logic [LANES-1:0]           line_data_i,
  input  wire logic [LANES-1:0]           line_frame_start_i,
  input  wire logic [LANES-1:0]           line_frame_odd_i,
  input  wire logic [LANES-1:0]           carrier_standard_select_i,
  input  wire logic [LANES-1:0]           inverse_mux_mode_i,
  input  wire logic [LANES-1:0]           link_strobe_form_select_i,
  input  wire logic [LANES-1:0][SA_W-1:0] national_bit_select_i,
  output logic      [LANES-1:0]           receive_link_stream_out_o,
  output logic      [LANES-1:0]           receive_link_strobe_o,
  output logic      [LANES-1:0]           link_fifo_stall_o
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic                stream_r;
    logic                strobe_r;
    logic                mark_r;
    logic                dbl_r;
    logic                stall_r;
    logic [BITCNT_W-1:0] bit_cnt;
    logic [HALF_W-1:0]   half_cnt;
    logic [HALF_W-1:0]   half_len;
  } lane_type;

  typedef struct packed {
    lane_type [LANES-1:0] lane;
  } tap_state_type;

  tap_state_type state_r;
  tap_state_type state_nxt;

  // ----------------------------------------------------------------
  // Data link bit decode
  // ----------------------------------------------------------------
  function automatic logic is_link_bit(input lane_cfg_type        cfg,
                                       input logic                odd,
                                       input logic [BITCNT_W-1:0] idx);
    logic [BITCNT_W-1:0] sa_idx;
    logic                hit;
    sa_idx = idx - E1_SA_FIRST;
    hit    = 1'b0;
    if (cfg.carrier_standard_select) begin
      hit = odd && (idx == T1_SBIT_POS);
    end else if (odd && idx >= E1_SA_FIRST && idx <= E1_SA_LAST) begin
      hit = cfg.national_bit_select[sa_idx[2:0]];
    end
    return hit;
  endfunction

  // ----------------------------------------------------------------
  // Per-lane synchronisers and FIFOs
  // ----------------------------------------------------------------
  logic [LANES-1:0][SYNC_W-1:0] syn_level;
  logic [LANES-1:0][SYNC_W-1:0] syn_rise;
  logic [LANES-1:0][SYNC_W-1:0] syn_fall;
  logic [LANES-1:0]             fifo_in_valid;
  logic [LANES-1:0]             fifo_in_ready;
  link_word_type [LANES-1:0]    fifo_in_data;
  logic [LANES-1:0]             fifo_out_valid;
  logic [LANES-1:0]             fifo_out_ready;
  link_word_type [LANES-1:0]    fifo_out_data;
  lane_cfg_type [LANES-1:0]     cfg;

  genvar g;
  generate
    for (g = 0; g < LANES; g++) begin : g_lane
      assign cfg[g] = '{carrier_standard_select: carrier_standard_select_i[g],
                        inverse_mux_mode:        inverse_mux_mode_i[g],
                        link_strobe_form_select: link_strobe_form_select_i[g],
                        national_bit_select:     national_bit_select_i[g]};

      link_sync #(
        .W (SYNC_W)
      ) u_sync (
        .clk_sys_i (clk_sys_i),
        .rst_n_i   (rst_n_i),
        .async_i   ({line_frame_odd_i[g], line_frame_start_i[g],
                     line_data_i[g], extracted_line_clock_in_i[g]}),
        .level_o   (syn_level[g]),
        .rise_o    (syn_rise[g]),
        .fall_o    (syn_fall[g])
      );

      link_fifo #(
        .W (WORD_W),
        .D (FIFO_DEPTH)
      ) u_fifo (
        .clk_sys_i   (clk_sys_i),
        .rst_n_i     (rst_n_i),
        .in_valid_i  (fifo_in_valid[g]),
        .in_ready_o  (fifo_in_ready[g]),
        .in_data_i   (fifo_in_data[g]),
        .out_valid_o (fifo_out_valid[g]),
        .out_ready_i (fifo_out_ready[g]),
        .out_data_o  (fifo_out_data[g])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // Lane behaviour
  // ----------------------------------------------------------------
  always_comb begin
    logic                clk_lvl;
    logic                clk_edge;
    logic                launch;
    logic [BITCNT_W-1:0] idx;
    lane_type            ln;
    clk_lvl   = 1'b0;
    clk_edge  = 1'b0;
    launch    = 1'b0;
    idx       = BITCNT_RST;
    ln        = '0;
    state_nxt = state_r;
    for (int l = 0; l < LANES; l++) begin
      ln       = state_r.lane[l];
      clk_lvl  = syn_level[l][SYN_CLK];
      clk_edge = syn_rise[l][SYN_CLK] | syn_fall[l][SYN_CLK];

      // Capture each decoded bit on the line clock rise, framing bits too
      idx = syn_level[l][SYN_FST] ? BITCNT_RST : ln.bit_cnt + 1'b1;
      fifo_in_valid[l]     = syn_rise[l][SYN_CLK];
      fifo_in_data[l].data = syn_level[l][SYN_DATA];
      fifo_in_data[l].mark = is_link_bit(cfg[l], syn_level[l][SYN_ODD], idx);
      if (syn_rise[l][SYN_CLK]) begin
        ln.bit_cnt = idx;
      end
      // A full FIFO drops the incoming bit; the line cannot be held off
      ln.stall_r = ~fifo_in_ready[l];

      // Launch edge follows the carrier standard
      launch = cfg[l].carrier_standard_select ? syn_rise[l][SYN_CLK]
                                              : syn_fall[l][SYN_CLK];
      fifo_out_ready[l] = launch;
      if (launch && fifo_out_valid[l]) begin
        ln.stream_r = fifo_out_data[l].data;
        ln.mark_r   = fifo_out_data[l].mark;
      end

      // Half-period measurement drives the E1 clock doubler
      if (clk_edge) begin
        ln.half_len = ln.half_cnt;
        ln.half_cnt = '0;
        ln.dbl_r    = ~ln.dbl_r;
      end else begin
        if (ln.half_cnt != HALF_SAT) begin
          ln.half_cnt = ln.half_cnt + 1'b1;
        end
        if (ln.half_cnt == (ln.half_len >> 1)) begin
          ln.dbl_r = ~ln.dbl_r;
        end
      end

      // Strobe selection
      if (cfg[l].inverse_mux_mode) begin
        ln.strobe_r = cfg[l].carrier_standard_select ? clk_lvl : ln.dbl_r;
      end else if (!cfg[l].link_strobe_form_select) begin
        ln.strobe_r = ln.mark_r;
      end else if (cfg[l].carrier_standard_select) begin
        // Rise on the line clock fall, mid-bit since T1 launches on the rise
        ln.strobe_r = ln.mark_r & ~clk_lvl;
      end else begin
        // E1 launches on the fall, so mid-bit is the line clock rise
        ln.strobe_r = ln.mark_r & clk_lvl;
      end
      state_nxt.lane[l] = ln;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_r <= '0;
    end else begin
      state_r <= state_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  always_comb begin
    for (int l = 0; l < LANES; l++) begin
      receive_link_stream_out_o[l] = state_r.lane[l].stream_r;
      receive_link_strobe_o[l]     = state_r.lane[l].strobe_r;
      link_fifo_stall_o[l]         = state_r.lane[l].stall_r;
    end
  end

endmodule // receive_link_tap

// ===== receive_link_tap_properties.sv
// Concurrent checks on lane 0 of the receive link tap
`timescale 1ns/100ps
module receive_link_tap_checker
  import rx_link_tap_pkg::*;
(
  input wire logic             clk_sys_i,
  input wire logic             rst_n_i,
  input wire logic [LANES-1:0] extracted_line_clock_in_i,
  input wire logic [LANES-1:0] carrier_standard_select_i,
  input wire logic [LANES-1:0] inverse_mux_mode_i,
  input wire logic [LANES-1:0] link_strobe_form_select_i,
  input wire logic [LANES-1:0] receive_link_stream_out_o,
  input wire logic [LANES-1:0] receive_link_strobe_o
);
  wire lc = extracted_line_clock_in_i[0];
  wire t1 = carrier_standard_select_i[0];
  wire im = inverse_mux_mode_i[0];
  wire fm = link_strobe_form_select_i[0];
  wire so = receive_link_stream_out_o[0];
  wire st = receive_link_strobe_o[0];
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  // Outputs trail the pins by 3-4 cycles, well inside a 6-cycle half period
  property p_t1_launch; t1 && !im && $stable(t1) && $changed(so) |-> lc; endproperty
  a_t1_launch:
    assert property (p_t1_launch) else $error("stream moved off line clock rise");
  property p_e1_launch; !t1 && !im && $stable(t1) && $changed(so) |-> !lc; endproperty
  a_e1_launch:
    assert property (p_e1_launch) else $error("stream moved off line clock fall");
  property p_t1_imux_hi; t1 && im && $rose(lc) |-> ##[2:6] (st || !(t1 && im)); endproperty
  a_t1_imux_hi:
    assert property (p_t1_imux_hi) else $error("strobe missed line clock high");
  property p_t1_imux_lo; t1 && im && $fell(lc) |-> ##[2:6] (!st || !(t1 && im)); endproperty
  a_t1_imux_lo:
    assert property (p_t1_imux_lo) else $error("strobe missed line clock low");
  property p_t1_gap_rise; t1 && !im && fm && $rose(st) |-> !lc; endproperty
  a_t1_gap_rise:
    assert property (p_t1_gap_rise) else $error("strobe rise not on line clock fall");
  property p_gap_width; !im && fm && $rose(st) |-> ##[3:9] !st; endproperty
  a_gap_width:
    assert property (p_gap_width) else $error("gapped strobe too long");
  property p_e1_gap_rise; !t1 && !im && fm && $rose(st) |-> lc; endproperty
  a_e1_gap_rise:
    assert property (p_e1_gap_rise) else $error("strobe rise not in line clock high");
  property p_en_width; !im && !fm && $rose(st) |-> st[*8]; endproperty
  a_en_width:
    assert property (p_en_width) else $error("enable shorter than a bit period");
  property p_e1_imux; !t1 && im && $changed(st) |-> ##[1:5] ($changed(st) || !im); endproperty
  a_e1_imux:
    assert property (p_e1_imux) else $error("doubled clock stopped toggling");
  c_t1_gap: cover property (t1 && fm && !im && $rose(st));
  c_e1_en: cover property (!t1 && !fm && !im && $rose(st));
  c_imux: cover property (im && $rose(st));
endmodule // receive_link_tap_checker

bind receive_link_tap receive_link_tap_checker i_receive_link_tap_checker (
  .clk_sys_i                 (clk_sys_i),
  .rst_n_i                   (rst_n_i),
  .extracted_line_clock_in_i (extracted_line_clock_in_i),
  .carrier_standard_select_i (carrier_standard_select_i),
  .inverse_mux_mode_i        (inverse_mux_mode_i),
  .link_strobe_form_select_i (link_strobe_form_select_i),
  .receive_link_stream_out_o (receive_link_stream_out_o),
  .receive_link_strobe_o     (receive_link_strobe_o)
);

// ===== receive_link_tap_test.sv
// Self-checking bench for the eight-lane receive link tap
`timescale 1ns/100ps
module receive_link_tap_test
  import rx_link_tap_pkg::*;
;
  logic                       clk_sys_i, rst_n_i, lclk, run_lclk, quiet, qf, d, mark;
  logic [LANES-1:0]           line_data, frame_start, frame_odd, t1, im, fm;
  logic [LANES-1:0]           stream, strobe, stall;
  logic [LANES-1:0][SA_W-1:0] nsel;
  logic [LANES-1:0][15:0]     cnt;
  logic [LANES-1:0][31:0]     bits;
  logic [8:0]                 idx;
  logic [1:0]                 fno;
  logic [15:0]                exp_cnt;
  logic [31:0]                exp_bits;
  int                         fails, n_compared;

  receive_link_tap i_receive_link_tap (
    .clk_sys_i                 (clk_sys_i),
    .rst_n_i                   (rst_n_i),
    .extracted_line_clock_in_i ({LANES{lclk}}),
    .line_data_i               (line_data),
    .line_frame_start_i        (frame_start),
    .line_frame_odd_i          (frame_odd),
    .carrier_standard_select_i (t1),
    .inverse_mux_mode_i        (im),
    .link_strobe_form_select_i (fm),
    .national_bit_select_i     (nsel),
    .receive_link_stream_out_o (stream),
    .receive_link_strobe_o     (strobe),
    .link_fifo_stall_o         (stall)
  );
  for (genvar k = 0; k < LANES; k++) begin : g_lane
    link_capture_model i_link_capture_model (.line_clk_i(lclk), .t1_i(t1[k]), .form_i(fm[k]),
      .stream_i(stream[k]), .strobe_i(strobe[k]), .count_o(cnt[k]), .bits_o(bits[k]));
  end
  // ----------------------------------------------------------------
  // Clocks and line framing
  // ----------------------------------------------------------------
  initial begin
    clk_sys_i = 1'b0;
    forever #2.5 clk_sys_i = ~clk_sys_i;
  end
  // Offset keeps line edges off the system clock edges
  initial begin
    lclk = 1'b0;
    wait (run_lclk);
    #1.3;
    forever #32 lclk = ~lclk;
  end
  always @(negedge lclk) begin
    if (idx >= (t1[0] ? 9'h0c0 : 9'h0ff)) begin
      idx = 9'h000;
      fno = fno + 2'h1;
      qf  = quiet;
    end else begin
      idx = idx + 9'h001;
    end
    d = idx[0] ^ idx[3] ^ fno[1];
    mark = fno[0] && !qf && (t1[0] ? idx == T1_SBIT_POS : (idx >= E1_SA_FIRST &&
           idx <= E1_SA_LAST && nsel[0][idx - E1_SA_FIRST]));
    if (mark) begin
      exp_cnt  = exp_cnt + 16'h0001;
      exp_bits = {exp_bits[30:0], d};
    end
    line_data   = {LANES{d}} ^ 8'haa;
    frame_start = {LANES{idx == 9'h000}};
    frame_odd   = {LANES{fno[0] & !qf}};
  end
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] expv);
    n_compared++;
    if (seen !== expv) begin
      fails++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, expv);
    end
  endtask
  task automatic set_cfg(input logic t, input logic i, input logic f, input logic [4:0] s);
    @(posedge clk_sys_i);
    #1;
    t1   = {LANES{t}};
    im   = {LANES{i}};
    fm   = {LANES{f}};
    nsel = {LANES{s}};
  endtask
  task automatic link_test(input logic t, input logic f, input logic [4:0] s, input string nm);
    logic [15:0] c0 [LANES];
    logic [31:0] mask;
    quiet = 1'b1;
    set_cfg(t, 1'b0, f, s);
    @(posedge frame_start[0]);
    foreach (c0[k]) c0[k] = cnt[k];
    exp_cnt = 16'h0000;
    quiet = 1'b0;
    repeat (4) @(posedge frame_start[0]);
    quiet = 1'b1;
    @(posedge frame_start[0]);
    mask = (32'h1 << exp_cnt) - 32'h1;
    for (int k = 0; k < LANES; k++) begin
      chk(32'(cnt[k] - c0[k]), 32'(exp_cnt));
      chk(bits[k] & mask, (exp_bits ^ {32{k[0]}}) & mask);
    end
    chk(32'(stall), 32'h0);
    $display("test %0s done", nm);
  endtask
  task automatic imux_test(input logic t, input int k_exp);
    logic [15:0] c0;
    int          dlt;
    set_cfg(t, 1'b1, 1'b1, 5'h00);
    repeat (4) @(posedge lclk);
    c0 = cnt[3];
    repeat (20) @(posedge lclk);
    dlt = int'(cnt[3] - c0);
    chk(32'(dlt >= k_exp - 1 && dlt <= k_exp + 1), 32'h1);
    set_cfg(t, 1'b0, 1'b1, 5'h00);
    repeat (4) @(posedge lclk);
    $display("test inverse mux done");
  endtask
  task automatic finish_test();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial begin
    {rst_n_i, run_lclk, d, mark, fno, exp_cnt, exp_bits, fails, n_compared} = '0;
    {quiet, qf, idx} = {2'h3, 9'h1ff};
    {line_data, frame_start, frame_odd, t1, im, fm, nsel} = '0;
    repeat (3) @(posedge clk_sys_i);
    chk(32'({stream, strobe, stall}), 32'h0);
    #1 rst_n_i = 1'b1;
    run_lclk = 1'b1;
    link_test(1'b1, 1'b1, 5'h1f, "t1 gapped");
    link_test(1'b1, 1'b0, 5'h00, "t1 enable");
    link_test(1'b0, 1'b1, 5'h15, "e1 gapped");
    link_test(1'b0, 1'b0, 5'h0a, "e1 enable");
    imux_test(1'b1, 20);
    imux_test(1'b0, 40);
    finish_test();
  end
  // Six frames per link test plus the clock tests need about 350 us; stays under 100k cycles
  initial begin
    #450_000;
    fails++;
    finish_test();
  end
endmodule // receive_link_tap_test

// ===== rx_link_tap_pkg.sv
// Shared constants and carrier types for the receive data link tap
package rx_link_tap_pkg;

  // ----------------------------------------------------------------
  // Structure
  // ----------------------------------------------------------------
  localparam int unsigned LANES      = 8;
  localparam int unsigned FIFO_DEPTH = 8;
  localparam int unsigned SA_W       = 5;
  localparam int unsigned BITCNT_W   = 9;
  localparam int unsigned HALF_W     = 8;
  localparam int unsigned SYNC_W     = 4;

  // ----------------------------------------------------------------
  // Rates and derived counts
  // ----------------------------------------------------------------
  localparam longint unsigned SYS_CLK_HZ  = 200_000_000;
  localparam longint unsigned T1_BIT_HZ   = 1_544_000;
  localparam longint unsigned E1_BIT_HZ   = 2_048_000;
  // Longest half line period, rounded up; the half-period counter saturates at HALF_SAT, well above it
  localparam longint unsigned HALF_MAX_CYC =
    (SYS_CLK_HZ + 2 * T1_BIT_HZ - 1) / (2 * T1_BIT_HZ);
  localparam logic [HALF_W-1:0] HALF_SAT = 8'hff;

  // ----------------------------------------------------------------
  // Bit positions inside a frame
  // ----------------------------------------------------------------
  localparam logic [BITCNT_W-1:0] T1_SBIT_POS  = 9'h000;
  localparam logic [BITCNT_W-1:0] E1_SA_FIRST  = 9'h003;
  localparam logic [BITCNT_W-1:0] E1_SA_LAST   = 9'h007;
  localparam logic [BITCNT_W-1:0] BITCNT_RST   = 9'h000;

  // ----------------------------------------------------------------
  // Synchroniser bit order
  // ----------------------------------------------------------------
  localparam int unsigned SYN_CLK  = 0;
  localparam int unsigned SYN_DATA = 1;
  localparam int unsigned SYN_FST  = 2;
  localparam int unsigned SYN_ODD  = 3;

  // One received line bit with its data link mark
  typedef struct packed {
    logic data;
    logic mark;
  } link_word_type;

  localparam int unsigned WORD_W = $bits(link_word_type);

  // Per-lane configuration as seen by the tap
  typedef struct packed {
    logic            carrier_standard_select;
    logic            inverse_mux_mode;
    logic            link_strobe_form_select;
    logic [SA_W-1:0] national_bit_select;
  } lane_cfg_type;

endpackage
